// File: rtl/scpwm_pkg.sv
package scpwm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CLKCTL  = 8'h8E;
	localparam logic [7:0] IDX_PER_LO  = 8'hD9;
	localparam logic [7:0] IDX_PER_HI  = 8'hD1;
	localparam logic [7:0] IDX_PIN_PRI = 8'hDE;
	localparam logic [7:0] IDX_PIN_ALT = 8'hC6;
	localparam logic [7:0] IDX_CTRL1   = 8'hDF;
	localparam logic [7:0] IDX_DT_EN   = 8'hF9;
	localparam logic [7:0] IDX_DT_CNT  = 8'hFA;
	localparam logic [7:0] IDX_UNLOCK  = 8'hC7;
	localparam logic [7:0] IDX_CNT_LO  = 8'hE0;
	localparam logic [7:0] IDX_CNT_HI  = 8'hE1;
	// Duty byte indices, element n is channel n
	localparam logic [5:0][7:0] IDX_DUTY_LO = {8'hCD, 8'hCC, 8'hDD, 8'hDC, 8'hDB, 8'hDA};
	localparam logic [5:0][7:0] IDX_DUTY_HI = {8'hC5, 8'hC4, 8'hD5, 8'hD4, 8'hD3, 8'hD2};
	// Field positions and writable masks
	localparam int         CTRL_TYP_BIT  = 4;
	localparam int         CTRL_MOD_LSB  = 6;
	localparam int         CLK_CKS_BIT   = 6;
	localparam int         DT_CNT8_BIT   = 4;
	localparam logic [7:0] PIN_PRI_MASK  = 8'h3F;
	localparam logic [7:0] PIN_ALT_MASK  = 8'h2E;
	localparam logic [7:0] CLK_MASK      = 8'h40;
	localparam logic [7:0] DT_EN_MASK    = 8'h17;
	// Reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [8:0]  RST_DT   = 9'h000;
	// Unlock keys
	localparam logic [7:0] KEY_FIRST  = 8'hAA;
	localparam logic [7:0] KEY_SECOND = 8'h55;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Sizes
	localparam int NUM_CH   = 6;
	localparam int NUM_PAIR = 3;
	// Pairing modes
	typedef enum logic [1:0] {
		MODE_INDEP = 2'b00,
		MODE_COMP  = 2'b01,
		MODE_SYNC  = 2'b10,
		MODE_RSVD  = 2'b11
	} scpwm_mode_t;
	// Unlock sequence states
	typedef enum logic [1:0] {TA_IDLE, TA_KEY1, TA_OPEN} scpwm_ta_t;
	// Pin group: drive level and PWM select per channel
	typedef struct packed {
		logic [5:0] level;
		logic [5:0] sel;
	} scpwm_pins_t;
endpackage

// File: rtl/scpwm_top.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
// Function
// - Edge type counts up from zero to period, then restarts at zero.
// - Edge type sets generator at zero, clears on duty match.
// - Center type counts up to period, then down to zero, repeating.
// - Center type clears on up-count match, sets on down-count match.
// - Edge period is period plus one ticks; high time is duty ticks.
// - Center period is twice period ticks; high time is twice duty.
// - Control bit 4 picks edge type at 0, center type at 1.
// - Mode field 7:6 picks independent, complementary, synchronized; 11 reserved.
// - Independent mode is reset default; each channel uses its own duty.
// - Complementary mode: odd channels invert even partner, ignore own duty.
// - Each pair has a nine-bit dead-time down-counter for the off gap.
// - With dead-time, each rising edge waits until the counter reaches zero.
// - Each pair has its own dead-time enable bit.
// - Dead-time registers accept writes only after the unlock sequence.
// - Dead-time acts only in complementary mode.
// - Duty value is sixteen bits from a high and a low byte.
// - Primary select bits 0 to 5 hand channel pins to PWM when set.
// - Alternate select bits 5, 3, 2, 1 hand alternate pins to PWM.
// - Clock source bit picks system clock at 0, timer 1 overflow at 1.
// - Dead gap is nine-bit count plus one system clocks.
// - Enable bits 0, 1, 2 serve pairs 0/1, 2/3, 4/5 rising edges.
// - Synchronized mode: odd channels copy their even partner in phase.
module scpwm_top
	import scpwm_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Timer 1 overflow pulse
	input  wire logic        t1_ovf,
	// AXI4-Lite write channels
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Output pins
	output scpwm_pins_t      pri_pins,
	output scpwm_pins_t      alt_pins
);
	// Register file
	logic [15:0]       per_q, per_d;
	logic [5:0][15:0]  duty_q, duty_d;
	logic [7:0]        ctrl_q, ctrl_d;
	logic [7:0]        psel_q, psel_d;
	logic [7:0]        asel_q, asel_d;
	logic [7:0]        clk_q, clk_d;
	logic [7:0]        dten_q, dten_d;
	logic [7:0]        dtlo_q, dtlo_d;
	scpwm_ta_t         ta_q, ta_d;
	// Bus state
	logic              awready_q, awready_d;
	logic              wready_q, wready_d;
	logic              bvalid_q, bvalid_d;
	logic [1:0]        bresp_q, bresp_d;
	logic              arready_q, arready_d;
	logic              rvalid_q, rvalid_d;
	logic [1:0]        rresp_q, rresp_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              aw_full_q, aw_full_d;
	logic [11:0]       wa_q, wa_d;
	logic              w_full_q, w_full_d;
	logic [7:0]        wd_q, wd_d;
	logic              wb_q, wb_d;
	// Counter and generators
	logic [15:0]       cnt_q, cnt_d;
	logic              up_q, up_d;
	logic [5:0]        gen_q, gen_d;
	// Pairing and dead-time
	logic [5:0]        raw;
	logic [2:0]        act;
	logic [2:0]        busy_q, busy_d;
	logic [2:0]        prev_q, prev_d;
	logic [2:0][8:0]   dc_q, dc_d;
	logic [5:0]        lvl_q, lvl_d;
	scpwm_pins_t       pri_q, pri_d;
	scpwm_pins_t       alt_q, alt_d;
	// Decoded helpers
	logic              wr_fire;
	logic              wr_ok;
	logic              wr_en;
	logic [7:0]        wr_ix;
	logic [8:0]        wr_look;
	logic [8:0]        rd_look;
	logic              tick;
	logic              typ;
	scpwm_mode_t       mode;
	logic [8:0]        dt_cnt;

	// Register read lookup: hit flag above the byte
	function automatic logic [8:0] rd_reg(input logic [7:0] ix);
		logic [8:0] r;
		r = {1'b1, RST_BYTE};
		case (ix)
			IDX_PER_LO:  r[7:0] = per_q[7:0];
			IDX_PER_HI:  r[7:0] = per_q[15:8];
			IDX_PIN_PRI: r[7:0] = psel_q;
			IDX_PIN_ALT: r[7:0] = asel_q;
			IDX_CTRL1:   r[7:0] = ctrl_q;
			IDX_CLKCTL:  r[7:0] = clk_q;
			IDX_DT_EN:   r[7:0] = dten_q;
			IDX_DT_CNT:  r[7:0] = dtlo_q;
			IDX_UNLOCK:  r[7:0] = {7'h00, ta_q == TA_OPEN};
			IDX_CNT_LO:  r[7:0] = cnt_q[7:0];
			IDX_CNT_HI:  r[7:0] = cnt_q[15:8];
			default:     r[8] = 1'b0;
		endcase
		for (int i = 0; i < NUM_CH; i++) begin
			if (ix == IDX_DUTY_LO[i])
				r = {1'b1, duty_q[i][7:0]};
			if (ix == IDX_DUTY_HI[i])
				r = {1'b1, duty_q[i][15:8]};
		end
		return r;
	endfunction

	// Register lookups; a process so that register changes are seen, not only index changes
	always_comb begin
		wr_look = rd_reg(wr_ix);
		rd_look = rd_reg(s_axi_araddr[9:2]);
	end

	// Decode
	assign wr_ix   = wa_q[9:2];
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign wr_ok   = (wa_q[11:10] == 2'b00) && wr_look[8];
	assign wr_en   = wr_fire && wr_ok && wb_q;
	assign typ     = ctrl_q[CTRL_TYP_BIT];
	assign mode    = scpwm_mode_t'(ctrl_q[CTRL_MOD_LSB +: 2]);
	assign dt_cnt  = {dten_q[DT_CNT8_BIT], dtlo_q};
	assign tick    = clk_q[CLK_CKS_BIT] ? t1_ovf : 1'b1;

	// Bus outputs
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign pri_pins      = pri_q;
	assign alt_pins      = alt_q;

	// AXI4-Lite handshakes; address and data latched in either order
	always_comb begin
		aw_full_d = aw_full_q;
		wa_d      = wa_q;
		w_full_d  = w_full_q;
		wd_d      = wd_q;
		wb_d      = wb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		if (s_axi_awvalid && awready_q) begin
			aw_full_d = 1'b1;
			wa_d      = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_full_d = 1'b1;
			wd_d     = s_axi_wdata[7:0];
			wb_d     = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		awready_d = !aw_full_d;
		wready_d  = !w_full_d;
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			if ((s_axi_araddr[11:10] == 2'b00) && rd_look[8]) begin
				rdata_d = {24'h00_0000, rd_look[7:0]};
				rresp_d = RESP_OKAY;
			end else begin
				rdata_d = 32'h0000_0000;
				rresp_d = RESP_SLVERR;
			end
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			aw_full_q <= 1'b0;
			wa_q      <= 12'h000;
			w_full_q  <= 1'b0;
			wd_q      <= RST_BYTE;
			wb_q      <= 1'b0;
		end else begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			aw_full_q <= aw_full_d;
			wa_q      <= wa_d;
			w_full_q  <= w_full_d;
			wd_q      <= wd_d;
			wb_q      <= wb_d;
		end
	end

	// Register writes and unlock sequence
	always_comb begin
		per_d  = per_q;
		duty_d = duty_q;
		ctrl_d = ctrl_q;
		psel_d = psel_q;
		asel_d = asel_q;
		clk_d  = clk_q;
		dten_d = dten_q;
		dtlo_d = dtlo_q;
		ta_d   = ta_q;
		if (wr_fire && wr_ok) begin
			case (ta_q)
				TA_IDLE: ta_d = (wr_ix == IDX_UNLOCK && wd_q == KEY_FIRST) ? TA_KEY1 : TA_IDLE;
				TA_KEY1: ta_d = (wr_ix == IDX_UNLOCK && wd_q == KEY_SECOND) ? TA_OPEN : TA_IDLE;
				default: ta_d = TA_IDLE;
			endcase
		end
		if (wr_en) begin
			case (wr_ix)
				IDX_PER_LO:  per_d[7:0] = wd_q;
				IDX_PER_HI:  per_d[15:8] = wd_q;
				IDX_PIN_PRI: psel_d = wd_q & PIN_PRI_MASK;
				IDX_PIN_ALT: asel_d = wd_q & PIN_ALT_MASK;
				IDX_CTRL1:   ctrl_d = wd_q;
				IDX_CLKCTL:  clk_d = wd_q & CLK_MASK;
				IDX_DT_EN:   if (ta_q == TA_OPEN) dten_d = wd_q & DT_EN_MASK;
				IDX_DT_CNT:  if (ta_q == TA_OPEN) dtlo_d = wd_q;
				default: ;
			endcase
			// Duty built from high and low bytes
			for (int i = 0; i < NUM_CH; i++) begin
				if (wr_ix == IDX_DUTY_LO[i])
					duty_d[i][7:0] = wd_q;
				if (wr_ix == IDX_DUTY_HI[i])
					duty_d[i][15:8] = wd_q;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_q  <= RST_WORD;
			duty_q <= '0;
			ctrl_q <= RST_BYTE;
			psel_q <= RST_BYTE;
			asel_q <= RST_BYTE;
			clk_q  <= RST_BYTE;
			dten_q <= RST_BYTE;
			dtlo_q <= RST_BYTE;
			ta_q   <= TA_IDLE;
		end else begin
			per_q  <= per_d;
			duty_q <= duty_d;
			ctrl_q <= ctrl_d;
			psel_q <= psel_d;
			asel_q <= asel_d;
			clk_q  <= clk_d;
			dten_q <= dten_d;
			dtlo_q <= dtlo_d;
			ta_q   <= ta_d;
		end
	end

	chk_ta_block: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && wr_ix == IDX_DT_CNT && ta_q != TA_OPEN |=> $stable(dtlo_q))
		else $error("dead-time count written while locked");

	// Shared counter and per-channel compare
	always_comb begin
		cnt_d = cnt_q;
		up_d  = up_q;
		gen_d = gen_q;
		if (tick) begin
			if (!typ) begin
				up_d  = 1'b1;
				cnt_d = (cnt_q >= per_q) ? RST_WORD : cnt_q + 16'h0001;
			end else if (up_q) begin
				if ({1'b0, cnt_q} + 17'h0_0001 >= {1'b0, per_q}) begin
					cnt_d = per_q;
					up_d  = 1'b0;
				end else begin
					cnt_d = cnt_q + 16'h0001;
				end
			end else if (cnt_q <= 16'h0001) begin
				cnt_d = RST_WORD;
				up_d  = 1'b1;
			end else begin
				cnt_d = cnt_q - 16'h0001;
			end
			// High from zero to match; down slope sets on its match
			for (int i = 0; i < NUM_CH; i++) begin
				if (typ && !up_q)
					gen_d[i] = cnt_q <= duty_q[i];
				else
					gen_d[i] = cnt_q < duty_q[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= RST_WORD;
			up_q  <= 1'b1;
			gen_q <= 6'h00;
		end else begin
			cnt_q <= cnt_d;
			up_q  <= up_d;
			gen_q <= gen_d;
		end
	end

	chk_edge_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && !typ && cnt_q >= per_q |=> cnt_q == RST_WORD)
		else $error("edge counter did not restart at period");
	chk_edge_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && !typ && cnt_q == duty_q[0] |=> !gen_q[0])
		else $error("edge generator not cleared on match");
	chk_edge_set: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && !typ && cnt_q == RST_WORD && duty_q[0] != RST_WORD |=> gen_q[0])
		else $error("edge generator not set at zero");
	chk_center_turn: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && typ && up_q && per_q != RST_WORD && cnt_q + 16'h0001 == per_q
		|=> !up_q && cnt_q == $past(per_q))
		else $error("center counter did not turn at period");
	chk_center_set: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && typ && !up_q && cnt_q == duty_q[0] && duty_q[0] != RST_WORD
		|=> gen_q[0])
		else $error("center generator not set on down match");
	chk_clk_src: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_q[CLK_CKS_BIT] && !t1_ovf |=> $stable(cnt_q) && $stable(up_q))
		else $error("counter moved without timer 1 overflow");

	// Pairing modes, dead-time per pair and pin gating
	always_comb begin
		for (int p = 0; p < NUM_PAIR; p++) begin
			raw[2*p] = gen_q[2*p];
			case (mode)
				MODE_COMP: raw[2*p+1] = ~gen_q[2*p];
				MODE_SYNC: raw[2*p+1] = gen_q[2*p];
				default:   raw[2*p+1] = gen_q[2*p+1];
			endcase
			act[p]    = (mode == MODE_COMP) && dten_q[p];
			prev_d[p] = raw[2*p];
			busy_d[p] = busy_q[p];
			dc_d[p]   = dc_q[p];
			if (!act[p]) begin
				busy_d[p] = 1'b0;
			end else if (raw[2*p] != prev_q[p]) begin
				busy_d[p] = 1'b1;
				dc_d[p]   = dt_cnt;
			end else if (busy_q[p]) begin
				if (dc_q[p] == RST_DT)
					busy_d[p] = 1'b0;
				else
					dc_d[p] = dc_q[p] - 9'h001;
			end
			// Rising edges held low while the gap runs
			lvl_d[2*p]   = raw[2*p] & ~busy_d[p];
			lvl_d[2*p+1] = raw[2*p+1] & ~busy_d[p];
		end
		pri_d.level = lvl_d & psel_q[5:0];
		pri_d.sel   = psel_q[5:0];
		alt_d.level = lvl_d & asel_q[5:0];
		alt_d.sel   = asel_q[5:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q <= 3'h0;
			prev_q <= 3'h0;
			dc_q   <= '0;
			lvl_q  <= 6'h00;
			pri_q  <= '0;
			alt_q  <= '0;
		end else begin
			busy_q <= busy_d;
			prev_q <= prev_d;
			dc_q   <= dc_d;
			lvl_q  <= lvl_d;
			pri_q  <= pri_d;
			alt_q  <= alt_d;
		end
	end

	// Count of three gives a four-cycle gap on the pin
	sequence dt_rise0;
		act[0] && $rose(raw[0]) && dt_cnt == 9'h003;
	endsequence
	sequence held_low0;
		!lvl_q[0] [*4];
	endsequence
	chk_dead_gap: assert property (@(posedge aclk) disable iff (!aresetn)
		dt_rise0 |=> held_low0)
		else $error("rising edge not held for dead gap");
	chk_comp_inv: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_COMP && !dten_q[0]) [*2] |-> lvl_q[1] != lvl_q[0])
		else $error("odd channel not inverse in complementary mode");
	chk_sync_copy: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_SYNC) [*2] |-> lvl_q[1] == lvl_q[0])
		else $error("odd channel not copy in synchronized mode");
	chk_indep_pass: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_INDEP) [*2] |-> lvl_q == $past(gen_q))
		else $error("independent output differs from generator");
	chk_pin_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!psel_q[0] |=> !pri_q.level[0] && !pri_q.sel[0])
		else $error("unselected primary pin driven");
endmodule

// File: sim/scpwm_drv_model.sv
`timescale 1ns/1ns
// Half-bridge gate driver model on the primary pins
module scpwm_drv_model
	import scpwm_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Gate inputs from the block
	input  wire scpwm_pins_t gate_pins,
	// Observation
	output logic [15:0]      shoot_cnt_q
);
	logic [15:0] shoot_cnt_d;
	logic        both_on;
	// Both switches of one leg on at once would short the rail
	always_comb begin
		both_on = 1'b0;
		for (int p = 0; p < NUM_PAIR; p++) begin
			if (gate_pins.level[2*p] && gate_pins.level[2*p+1]) begin
				both_on = 1'b1;
			end
		end
		shoot_cnt_d = shoot_cnt_q + {15'h0000, both_on};
	end
	// Overlap cycle counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shoot_cnt_q <= 16'h0000;
		end else begin
			shoot_cnt_q <= shoot_cnt_d;
		end
	end
endmodule

// File: sim/six_channel_pwm_core_tb_top.sv
`timescale 1ns/1ns
module six_channel_pwm_core_tb_top
	import scpwm_pkg::*;
;
	logic        aclk, aresetn, t1_ovf;
	logic [11:0] awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rr;
	scpwm_pins_t pri_pins, alt_pins;
	logic [15:0] shoot_cnt, shoot0;
	int          error_cnt, check_count;
	int          hi[6];
	int          gap[3];
	// Device and gate driver
	scpwm_top dut (.aclk(aclk), .aresetn(aresetn), .t1_ovf(t1_ovf),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pri_pins(pri_pins),
		.alt_pins(alt_pins));
	scpwm_drv_model drv (.aclk(aclk), .aresetn(aresetn), .gate_pins(pri_pins),
		.shoot_cnt_q(shoot_cnt));
	// 125 MHz clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Write one register; address and data offered together
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] dat, input logic [1:0] er);
		bit aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0000, dat};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awready && !aw_ok) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (wready && !w_ok) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
		check(bresp, er);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
		axi_wr(idx, dat, RESP_OKAY);
	endtask
	// Read one register into rd and rr
	task automatic axi_rd(input logic [7:0] idx);
		@(posedge aclk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rd = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	// Count high cycles per pin and both-low cycles per pair
	task automatic measure(input int settle, input int n);
		hi = '{default: 0};
		gap = '{default: 0};
		repeat (settle) @(posedge aclk);
		repeat (n) begin
			@(posedge aclk);
			for (int c = 0; c < NUM_CH; c++) if (pri_pins.level[c] === 1'b1) hi[c]++;
			for (int p = 0; p < NUM_PAIR; p++) begin
				if (pri_pins.level[2*p] === 1'b0 && pri_pins.level[2*p+1] === 1'b0) gap[p]++;
			end
		end
	endtask
	task automatic t_reset();
		check({8'h00, pri_pins, alt_pins}, 32'h0000_0000);
		axi_rd(IDX_CTRL1);
		check(rd, 32'h0000_0000);
		axi_rd(IDX_DUTY_HI[4]);
		check(rd, 32'h0000_0000);
		axi_rd(IDX_DUTY_HI[5]);
		check(rd, 32'h0000_0000);
		axi_rd(IDX_PIN_PRI);
		check(rd, 32'h0000_0000);
		axi_rd(8'h00);
		check({30'h0, rr}, {30'h0, RESP_SLVERR});
		axi_wr(8'h01, 8'h5A, RESP_SLVERR);
	endtask
	task automatic t_edge_pins();
		wr(IDX_PER_LO, 8'h09);
		wr(IDX_DUTY_LO[0], 8'h03);
		wr(IDX_DUTY_LO[1], 8'h04);
		wr(IDX_DUTY_HI[1], 8'h01);
		wr(IDX_PIN_PRI, 8'hFF);
		axi_rd(IDX_DUTY_HI[1]);
		check(rd, 32'h0000_0001);
		measure(20, 40);
		check(hi[0], 12);
		check(hi[1], 40);
		check(pri_pins.sel, 6'h3F);
		wr(IDX_PIN_PRI, 8'h15);
		wr(IDX_PIN_ALT, 8'hFF);
		// Pin flops follow the select register one edge later
		@(posedge aclk);
		check(alt_pins.sel, PIN_ALT_MASK[5:0]);
		check(alt_pins.level, 6'h02);
		measure(0, 20);
		check(hi[1], 0);
		check(hi[0], 6);
		wr(IDX_PIN_PRI, 8'h3F);
	endtask
	task automatic t_center();
		wr(IDX_PER_LO, 8'h08);
		wr(IDX_CTRL1, 8'h10);
		measure(32, 32);
		check(hi[0], 12);
		check(hi[1], 32);
		wr(IDX_CTRL1, 8'h00);
	endtask
	task automatic t_modes();
		int exp1[4];
		exp1 = '{24, 28, 12, 24};
		wr(IDX_PER_LO, 8'h09);
		wr(IDX_DUTY_HI[1], 8'h00);
		wr(IDX_DUTY_LO[1], 8'h06);
		for (int m = 0; m < 4; m++) begin
			wr(IDX_CTRL1, 8'(m << CTRL_MOD_LSB));
			measure(20, 40);
			check(hi[0], 12);
			check(hi[1], exp1[m]);
		end
	endtask
	task automatic t_deadtime();
		wr(IDX_DT_CNT, 8'h03);
		axi_rd(IDX_DT_CNT);
		check(rd, 32'h0000_0000);
		wr(IDX_UNLOCK, KEY_FIRST);
		wr(IDX_UNLOCK, KEY_SECOND);
		wr(IDX_DT_CNT, 8'h03);
		wr(IDX_UNLOCK, KEY_FIRST);
		wr(IDX_UNLOCK, KEY_SECOND);
		wr(IDX_DT_EN, 8'h01);
		axi_rd(IDX_DT_EN);
		check(rd, 32'h0000_0001);
		wr(IDX_PER_LO, 8'h13);
		wr(IDX_DUTY_LO[0], 8'h0A);
		wr(IDX_DUTY_LO[2], 8'h0A);
		wr(IDX_CTRL1, 8'h40);
		// Let the last old-mode pin sample reach the overlap count first
		repeat (2) @(posedge aclk);
		shoot0 = shoot_cnt;
		measure(40, 60);
		check(hi[0], 18);
		check(hi[1], 18);
		check(gap[0], 24);
		check(gap[1], 0);
		check(shoot_cnt - shoot0, 16'h0000);
		wr(IDX_CTRL1, 8'h80);
		measure(40, 60);
		check(hi[0], 30);
		check(gap[0], 30);
	endtask
	task automatic t_clksrc();
		logic [31:0] a;
		wr(IDX_CTRL1, 8'h00);
		wr(IDX_CLKCTL, CLK_MASK);
		axi_rd(IDX_CNT_LO);
		a = rd;
		repeat (10) @(posedge aclk);
		axi_rd(IDX_CNT_LO);
		check(rd, a);
		repeat (5) begin
			@(posedge aclk);
			t1_ovf <= 1'b1;
			@(posedge aclk);
			t1_ovf <= 1'b0;
		end
		axi_rd(IDX_CNT_LO);
		check(rd, (a + 5) % 20);
		wr(IDX_CLKCTL, 8'h00);
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		test_done();
	end
	// Main sequence
	initial begin
		error_cnt = 0;
		check_count = 0;
		aresetn = 1'b0;
		t1_ovf = 1'b0;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0000_0000;
		wstrb = 4'h1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_edge_pins();
		t_center();
		t_modes();
		t_deadtime();
		t_clksrc();
		test_done();
	end
endmodule
